// ---- design/flash_host_pkg.sv ----
// Purpose: shared constants and types for the flash command host
// Assumes: 100 MHz ref clock, word-wide (16 bit) parallel flash bus
// Notes: command codes occupy the low byte of the data bus
package flash_host_pkg;
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int CLK_MHZ = 100;
  localparam int COLLECT_US = 80;
  localparam int SUSPEND_US = 20;
  // longest suspend latency in whole reference clock cycles
  localparam int SUSPEND_CYC = SUSPEND_US * CLK_MHZ;
  localparam int TMR_W = 16;
  localparam int TICK_DIV = 4;
  localparam int STROBE_TICKS = 2;
  localparam int SEQ_MAX = 6;
  localparam int SEQ_W = 3;
  localparam logic [SEQ_W-1:0] LEN_ONE = 3'h1;
  localparam logic [SEQ_W-1:0] LEN_TWO = 3'h2;
  localparam logic [SEQ_W-1:0] LEN_THREE = 3'h3;
  localparam logic [SEQ_W-1:0] LEN_ERASE = 3'h6;
  localparam logic [7:0] CODE_UNLOCK1 = 8'haa;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CODE_RESUME = 8'h30;
  localparam logic [7:0] CODE_SUSPEND = 8'hb0;
  localparam logic [7:0] CODE_BYP_ENTER = 8'h20;
  localparam logic [7:0] CODE_BYP_PROG = 8'ha0;
  localparam logic [7:0] CODE_BYP_EXIT1 = 8'h90;
  localparam logic [7:0] CODE_BYP_EXIT2 = 8'h00;
  localparam logic [7:0] CODE_RESET = 8'hf0;
  localparam logic [ADDR_W-1:0] UNLOCK1_WORD = 23'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK2_WORD = 23'h0002aa;
  localparam logic [ADDR_W-1:0] UNLOCK1_BYTE = 23'h000aaa;
  localparam logic [ADDR_W-1:0] UNLOCK2_BYTE = 23'h000555;
  localparam logic [ADDR_W-1:0] ADDR_DONT_CARE = 23'h000000;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int ERASE_TOGGLE_BIT = 2;

  typedef enum logic [2:0] {
    CMD_READ, CMD_SECTOR_ERASE, CMD_SUSPEND, CMD_RESUME,
    CMD_BYP_ENTER, CMD_BYP_PROG, CMD_BYP_RESET, CMD_RESET
  } cmd_t;

  typedef enum logic [2:0] {
    MODE_READ, MODE_COLLECT, MODE_ERASE, MODE_SUSP_WAIT, MODE_SUSP, MODE_BYPASS
  } mode_t;

  typedef struct packed {
    cmd_t cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } req_t;

  typedef struct packed {
    logic refused;
    logic [DATA_W-1:0] data;
    logic polling_status_bit;
    logic toggle_status_bit;
    logic erase_toggle_bit;
  } resp_t;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bus_cyc_t;
endpackage : flash_host_pkg

// ---- design/flash_bus_cycle.sv ----
// Purpose: one asynchronous flash bus cycle (write or read) per start pulse
// Assumes: the flash samples address on WE fall and data on WE rise
// Notes: phases advance on a divided tick so write strobes are STROBE_TICKS ticks of TICK_DIV clocks wide, read strobes at least that
module flash_bus_cycle
  import flash_host_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input bus_cyc_t cyc_in,
  input wire logic [DATA_W-1:0] dq_in,
  output logic done_out,
  output logic [DATA_W-1:0] rdata_out,
  output logic [ADDR_W-1:0] addr_out,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_out,
  output logic ce_n_out,
  output logic we_n_out,
  output logic oe_n_out
);
  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} phase_t;

  phase_t ph_q, ph_d;
  logic [1:0] div_q, div_d, cnt_q, cnt_d;
  bus_cyc_t cyc_q, cyc_d;
  logic [DATA_W-1:0] rdata_q, rdata_d, s1_q, s2_q, s3_q;
  logic done_q, done_d, ce_n_q, ce_n_d, we_n_q, we_n_d, oe_n_q, oe_n_d, oe_q, oe_d;
  logic tick;

  // phase sequencing; a read waits until the synchronised bus has settled
  always_comb begin
    div_d = (div_q == 2'(TICK_DIV - 1)) ? 2'h0 : div_q + 2'h1;
    tick = (div_q == 2'(TICK_DIV - 1));
    ph_d = ph_q;
    cnt_d = cnt_q;
    cyc_d = cyc_q;
    rdata_d = rdata_q;
    done_d = 1'b0;
    case (ph_q)
      PH_IDLE: begin
        if (start_in) begin
          ph_d = PH_SETUP;
          cyc_d = cyc_in;
        end
      end
      PH_SETUP: begin
        if (tick) begin
          ph_d = PH_STROBE;
          cnt_d = 2'h0;
        end
      end
      PH_STROBE: begin
        if (tick) begin
          if (cnt_q != 2'(STROBE_TICKS - 1)) begin
            cnt_d = cnt_q + 2'h1;
          end else if (cyc_q.wr || (s2_q == s3_q)) begin
            ph_d = PH_HOLD;
            if (!cyc_q.wr) begin
              rdata_d = s3_q;
            end
          end
        end
      end
      PH_HOLD: begin
        if (tick) begin
          ph_d = PH_IDLE;
          done_d = 1'b1;
        end
      end
      default: ph_d = PH_IDLE;
    endcase
    // pins are registered from the next phase so they never glitch
    ce_n_d = (ph_d == PH_IDLE);
    we_n_d = !((ph_d == PH_STROBE) && cyc_d.wr);
    oe_n_d = !((ph_d == PH_STROBE) && !cyc_d.wr);
    oe_d = (ph_d != PH_IDLE) && cyc_d.wr;
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ph_q <= PH_IDLE;
      div_q <= 2'h0;
      cnt_q <= 2'h0;
      cyc_q <= '0;
      rdata_q <= '0;
      done_q <= 1'b0;
      ce_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      oe_q <= 1'b0;
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      ph_q <= ph_d;
      div_q <= div_d;
      cnt_q <= cnt_d;
      cyc_q <= cyc_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
      ce_n_q <= ce_n_d;
      we_n_q <= we_n_d;
      oe_n_q <= oe_n_d;
      oe_q <= oe_d;
      s1_q <= dq_in; // pin data crosses in here
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign done_out = done_q;
  assign rdata_out = rdata_q;
  assign addr_out = cyc_q.addr;
  assign dq_out = cyc_q.data;
  assign dq_oe_out = oe_q;
  assign ce_n_out = ce_n_q;
  assign we_n_out = we_n_q;
  assign oe_n_out = oe_n_q;
endmodule : flash_bus_cycle

// ---- design/flash_host_ctrl.sv ----
// Purpose: host-side command sequencer for a banked NOR flash with erase suspend
// Assumes: one request at a time; reads may be issued in any mode
// Notes: host tracks the bank mode itself and refuses illegal commands
// Contract
// R1: suspend B0 only during erase or collection
// R2: no suspend during chip erase, program
// R3: suspended state reached within 20 us
// R4: suspend during collection suspends at once
// R5: suspend address bits besides bank ignored
// R6: suspended bank reads, programs unchosen sectors; host refuses programs while suspended
// R7: suspended sector reads return status byte
// R8: polling bit shows erasing versus suspended
// R9: suspended program completes back to suspend; host issues no program while suspended
// R10: autoselect allowed while erase suspended; host has no autoselect command
// R11: autoselect exit returns to suspended state
// R12: resume is one cycle at bank address
// R13: resume code 30 only while suspended
// R14: after resume, resume refused, suspend allowed
// R15: bypass program: A0, then target and payload
// R16: bypass exit: 90 at bank, 00
// R17: sector erase six cycles AA 55 80 AA 55 30
// R18: suspend is one B0 write to bank
// R19: bypass mode takes only bypass program, reset
// R20: collection ends on other commands, reads array; host refuses those, collection ends only on timer or suspend
// R21: polling bit zero erasing, one when done
// R22: F0 reset returns bank to read state
// R23: byte mode unlocks use AAA and 555
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int COLLECT_CYC = COLLECT_US * CLK_MHZ
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic byte_mode_in,
  input wire logic req_valid_in,
  input req_t req_in,
  output logic req_ready_out,
  output logic resp_valid_out,
  output resp_t resp_out,
  output mode_t mode_out,
  output logic [ADDR_W-1:0] flash_addr_out,
  output logic [DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_out,
  input wire logic [DATA_W-1:0] flash_dq_in,
  output logic flash_ce_n_out,
  output logic flash_we_n_out,
  output logic flash_oe_n_out,
  output logic flash_byte_n_out
);
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_RESP} ctl_t;

  ctl_t st_q, st_d;
  mode_t mode_q, mode_d;
  cmd_t cmd_q, cmd_d;
  bus_cyc_t seq_q [SEQ_MAX];
  bus_cyc_t seq_d [SEQ_MAX];
  bus_cyc_t seq_n [SEQ_MAX];
  logic [SEQ_W-1:0] len_q, len_d, len_n, idx_q, idx_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [ADDR_W-1:0] erase_addr_q, erase_addr_d, u1, u2;
  resp_t resp_q, resp_d;
  logic go_q, go_d, byte_n_q, legal, accept, bus_done, fin;
  logic [DATA_W-1:0] bus_rdata;

  function automatic bus_cyc_t wcyc(input logic [ADDR_W-1:0] a, input logic [7:0] c);
    wcyc = '{wr: 1'b1, addr: a, data: {{(DATA_W - 8){1'b0}}, c}};
  endfunction : wcyc

  assign accept = (st_q == ST_IDLE) && req_valid_in;
  assign fin = (st_q == ST_RUN) && bus_done && (idx_q == len_q - LEN_ONE);

  // legality against the tracked mode, and the write cycles to issue
  always_comb begin
    // R23 byte mode unlocks
    u1 = byte_mode_in ? UNLOCK1_BYTE : UNLOCK1_WORD;
    u2 = byte_mode_in ? UNLOCK2_BYTE : UNLOCK2_WORD;
    seq_n = '{default: '0};
    len_n = LEN_ONE;
    legal = 1'b0;
    case (req_in.cmd)
      CMD_READ: begin
        // R7 status reads need no command
        legal = 1'b1;
        seq_n[0] = '{wr: 1'b0, addr: req_in.addr, data: '0};
      end
      CMD_SECTOR_ERASE: begin
        // R17 full six-cycle sequence
        if (mode_q == MODE_READ) begin
          legal = 1'b1;
          len_n = LEN_ERASE;
          seq_n[0] = wcyc(u1, CODE_UNLOCK1);
          seq_n[1] = wcyc(u2, CODE_UNLOCK2);
          seq_n[2] = wcyc(u1, CODE_ERASE_SETUP);
          seq_n[3] = wcyc(u1, CODE_UNLOCK1);
          seq_n[4] = wcyc(u2, CODE_UNLOCK2);
          seq_n[5] = wcyc(req_in.addr, CODE_SECTOR_ERASE);
        end else if (mode_q == MODE_COLLECT) begin
          legal = 1'b1; // another sector while collecting
          seq_n[0] = wcyc(req_in.addr, CODE_SECTOR_ERASE);
        end
      end
      CMD_SUSPEND: begin
        // R1 R2 R18 only while a sector erase runs
        legal = (mode_q == MODE_COLLECT) || (mode_q == MODE_ERASE);
        seq_n[0] = wcyc(req_in.addr, CODE_SUSPEND);
      end
      CMD_RESUME: begin
        // R12 R13 R14 only while suspended
        legal = (mode_q == MODE_SUSP);
        seq_n[0] = wcyc(req_in.addr, CODE_RESUME);
      end
      CMD_BYP_ENTER: begin
        legal = (mode_q == MODE_READ);
        len_n = LEN_THREE;
        seq_n[0] = wcyc(u1, CODE_UNLOCK1);
        seq_n[1] = wcyc(u2, CODE_UNLOCK2);
        seq_n[2] = wcyc(u1, CODE_BYP_ENTER);
      end
      CMD_BYP_PROG: begin
        // R15 R19 two-cycle program
        legal = (mode_q == MODE_BYPASS);
        len_n = LEN_TWO;
        seq_n[0] = wcyc(ADDR_DONT_CARE, CODE_BYP_PROG);
        seq_n[1] = '{wr: 1'b1, addr: req_in.addr, data: req_in.data};
      end
      CMD_BYP_RESET: begin
        // R16 R19 two-cycle exit
        legal = (mode_q == MODE_BYPASS);
        len_n = LEN_TWO;
        seq_n[0] = wcyc(req_in.addr, CODE_BYP_EXIT1);
        seq_n[1] = wcyc(ADDR_DONT_CARE, CODE_BYP_EXIT2);
      end
      CMD_RESET: begin
        // R22 R11 reset only where it cannot abort an erase
        legal = (mode_q == MODE_READ) || (mode_q == MODE_SUSP);
        seq_n[0] = wcyc(ADDR_DONT_CARE, CODE_RESET);
      end
      default: legal = 1'b0;
    endcase
  end

  // control flow, mode tracking and timers
  always_comb begin
    st_d = st_q;
    mode_d = mode_q;
    cmd_d = cmd_q;
    seq_d = seq_q;
    len_d = len_q;
    idx_d = idx_q;
    tmr_d = tmr_q;
    erase_addr_d = erase_addr_q;
    resp_d = resp_q;
    go_d = 1'b0;
    // R20 collection window closes into erase
    if (mode_q == MODE_COLLECT || mode_q == MODE_SUSP_WAIT) begin
      if (tmr_q != '0) begin
        tmr_d = tmr_q - 1'b1;
      end else begin
        // R3 bounded wait before treating bank as suspended
        mode_d = (mode_q == MODE_COLLECT) ? MODE_ERASE : MODE_SUSP;
      end
    end
    case (st_q)
      ST_IDLE: begin
        if (accept) begin
          cmd_d = req_in.cmd;
          resp_d = '0;
          if (legal) begin
            st_d = ST_RUN;
            seq_d = seq_n;
            len_d = len_n;
            idx_d = '0;
            go_d = 1'b1;
          end else begin
            st_d = ST_RESP;
            resp_d.refused = 1'b1;
          end
        end
      end
      ST_RUN: begin
        if (bus_done && !fin) begin
          idx_d = idx_q + LEN_ONE;
          go_d = 1'b1;
        end
        if (fin) begin
          st_d = ST_RESP;
          resp_d.data = bus_rdata;
          resp_d.polling_status_bit = bus_rdata[POLL_BIT];
          resp_d.toggle_status_bit = bus_rdata[TOGGLE_BIT];
          resp_d.erase_toggle_bit = bus_rdata[ERASE_TOGGLE_BIT];
          case (cmd_q)
            CMD_SECTOR_ERASE: begin
              mode_d = MODE_COLLECT;
              tmr_d = TMR_W'(COLLECT_CYC);
              erase_addr_d = seq_q[len_q - LEN_ONE].addr;
            end
            CMD_SUSPEND: begin
              // R4 collection window ends at once
              if (mode_q == MODE_COLLECT) begin
                mode_d = MODE_SUSP;
              end else begin
                mode_d = MODE_SUSP_WAIT;
                tmr_d = TMR_W'(SUSPEND_CYC);
              end
            end
            CMD_RESUME: mode_d = MODE_ERASE;
            CMD_BYP_ENTER: mode_d = MODE_BYPASS;
            CMD_BYP_RESET: mode_d = MODE_READ;
            CMD_READ: begin
              // R8 R21 polling bit one ends erasing or the suspend wait
              if (seq_q[0].addr == erase_addr_q && bus_rdata[POLL_BIT]) begin
                if (mode_q == MODE_ERASE) begin
                  mode_d = MODE_READ;
                end else if (mode_q == MODE_SUSP_WAIT) begin
                  mode_d = MODE_SUSP;
                end
              end
            end
            default: mode_d = mode_d;
          endcase
        end
      end
      ST_RESP: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= ST_IDLE;
      mode_q <= MODE_READ;
      cmd_q <= CMD_READ;
      seq_q <= '{default: '0};
      len_q <= LEN_ONE;
      idx_q <= '0;
      tmr_q <= '0;
      erase_addr_q <= '0;
      resp_q <= '0;
      go_q <= 1'b0;
      byte_n_q <= 1'b1;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      cmd_q <= cmd_d;
      seq_q <= seq_d;
      len_q <= len_d;
      idx_q <= idx_d;
      tmr_q <= tmr_d;
      erase_addr_q <= erase_addr_d;
      resp_q <= resp_d;
      go_q <= go_d;
      byte_n_q <= !byte_mode_in;
    end
  end

  flash_bus_cycle u_bus (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .start_in(go_q),
    .cyc_in(seq_q[idx_q]),
    .dq_in(flash_dq_in),
    .done_out(bus_done),
    .rdata_out(bus_rdata),
    .addr_out(flash_addr_out),
    .dq_out(flash_dq_out),
    .dq_oe_out(flash_dq_oe_out),
    .ce_n_out(flash_ce_n_out),
    .we_n_out(flash_we_n_out),
    .oe_n_out(flash_oe_n_out)
  );

  assign req_ready_out = (st_q == ST_IDLE);
  assign resp_valid_out = (st_q == ST_RESP);
  assign resp_out = resp_q;
  assign mode_out = mode_q;
  assign flash_byte_n_out = byte_n_q;

  // helper: cycles spent waiting for the suspend to settle
  logic [TMR_W-1:0] wait_cnt_q;
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_cnt_q <= '0;
    end else begin
      wait_cnt_q <= (mode_q == MODE_SUSP_WAIT) ? wait_cnt_q + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  susp_accept_a: assert property ( // R1
    accept && req_in.cmd == CMD_SUSPEND && (mode_q == MODE_COLLECT || mode_q == MODE_ERASE)
    |=> st_q == ST_RUN && seq_q[0].data[7:0] == CODE_SUSPEND)
    else $error("suspend not issued during erase");
  susp_refuse_a: assert property ( // R2
    accept && req_in.cmd == CMD_SUSPEND && mode_q != MODE_COLLECT && mode_q != MODE_ERASE
    |=> resp_valid_out && resp_out.refused && flash_ce_n_out)
    else $error("suspend sent outside erase");
  susp_wait_a: assert property ( // R3
    wait_cnt_q <= TMR_W'(SUSPEND_CYC + 1))
    else $error("suspend wait exceeds limit");
  collect_susp_a: assert property ( // R4
    fin && cmd_q == CMD_SUSPEND && mode_q == MODE_COLLECT |=> mode_q == MODE_SUSP)
    else $error("suspend in collection did not take effect at once");
  resume_refuse_a: assert property ( // R13
    accept && req_in.cmd == CMD_RESUME && mode_q != MODE_SUSP |=> resp_out.refused)
    else $error("resume sent while not suspended");
  resume_erase_a: assert property ( // R14
    fin && cmd_q == CMD_RESUME |=> mode_q == MODE_ERASE)
    else $error("resume did not return to erasing");
  erase_len_a: assert property ( // R17
    accept && req_in.cmd == CMD_SECTOR_ERASE && mode_q == MODE_READ
    |=> len_q == LEN_ERASE && seq_q[2].data[7:0] == CODE_ERASE_SETUP)
    else $error("sector erase sequence malformed");
  bypass_only_a: assert property ( // R19
    accept && mode_q == MODE_BYPASS && req_in.cmd != CMD_READ
    && req_in.cmd != CMD_BYP_PROG && req_in.cmd != CMD_BYP_RESET |=> resp_out.refused)
    else $error("invalid command sent in bypass");
  collect_end_a: assert property ( // R20
    mode_q == MODE_COLLECT && tmr_q == '0 && !fin |=> mode_q == MODE_ERASE)
    else $error("collection window did not close");
  byte_unlock_a: assert property ( // R23
    accept && (req_in.cmd == CMD_SECTOR_ERASE || req_in.cmd == CMD_BYP_ENTER)
    && mode_q == MODE_READ && byte_mode_in
    |=> seq_q[0].addr == UNLOCK1_BYTE && seq_q[1].addr == UNLOCK2_BYTE)
    else $error("byte mode unlock address wrong");
  bus_done_a: assert property ( // R15
    $rose(st_q == ST_RUN) |-> ##[1:200] (st_q != ST_RUN))
    else $error("command sequence did not finish");

  erase_cover_c: cover property (fin && cmd_q == CMD_SECTOR_ERASE);
  suspend_cover_c: cover property (mode_q == MODE_SUSP ##[1:1000] mode_q == MODE_ERASE);
  bypass_cover_c: cover property (fin && cmd_q == CMD_BYP_PROG);
  refuse_cover_c: cover property (resp_valid_out && resp_out.refused);
endmodule : flash_host_ctrl

// ---- verif/flash_device_model.sv ----
// Purpose: behavioural banked flash seen from its pins, one bank modelled
// Assumes: writes latch on the write strobe rise while chip select is low
// Notes: erasure never finishes by itself; a released bus shows inverted data
module flash_device_model
  import flash_host_pkg::*;
(
  input wire logic rstn_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  output logic [DATA_W-1:0] dq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [ADDR_W+DATA_W-1:0] wr_log [0:63];
  int n_wr = 0;
  int st;
  logic [39:0] hist;
  logic [255:0] chosen;
  logic [7:0] d;
  logic tog = 1'b0;
  logic etog = 1'b0;
  logic insec;
  logic [DATA_W-1:0] rd;

  // command decode; st 0 read, 1 collect, 2 erase, 3 suspended, 4 bypass
  always @(posedge we_n_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st = 0;
      hist = '0;
      chosen = '0;
    end else if (!ce_n_in) begin
      d = dq_in[7:0];
      wr_log[n_wr % 64] = {addr_in, dq_in};
      n_wr++;
      // bypass leaves only on 90 then 00
      if (st == 4) begin
        if (hist[7:0] == 8'h90 && d == 8'h00) st = 0;
      // suspend only while erasing, at once
      end else if (d == 8'hb0 && (st == 1 || st == 2)) st = 3;
      // suspended state holds until a resume
      else if (d == 8'h30 && st == 3) st = 2;
      // six-cycle sector erase opens collection; a further sector joins it
      else if (d == 8'h30 && (st == 1 || hist == 40'haa5580aa55)) begin
        st = 1;
        chosen[addr_in[22:15]] = 1'b1;
      end else if (d == 8'h20 && hist[15:0] == 16'haa55 && st == 0) st = 4;
      else if (st == 1 && d != 8'haa && d != 8'h55 && d != 8'h80) st = 0;
      hist = {hist[31:0], d};
    end
  end

  // toggle bits flip on read strobes in collect or erase; erase toggle also when suspended, in chosen sectors only
  always @(negedge oe_n_in) begin
    if (st == 1 || st == 2) tog = ~tog;
    if (st >= 1 && st <= 3 && insec) etog = ~etog;
  end

  // chosen sectors answer with the status byte
  assign insec = chosen[addr_in[22:15]];
  assign rd = (st >= 1 && st <= 3 && insec) ?
      {8'h00, st == 3, tog, 3'b000, etog, 2'b00} : addr_in[15:0] ^ 16'h5a5a;
  // the inverse when released, so a stale value can never pass for a read
  assign dq_out = oe_n_in ? ~rd : rd;
endmodule : flash_device_model

// ---- verif/test_flash_host_ctrl.sv ----
// Purpose: self-checking bench for the flash command host
// Assumes: host answers every taken request with one resp pulse
// Notes: collection time shortened through COLLECT_CYC
module test_flash_host_ctrl
  import flash_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [ADDR_W-1:0] SEC_A = 23'h0a8000;
  localparam logic [ADDR_W-1:0] SEC_B = 23'h0b0123;
  localparam logic [ADDR_W-1:0] OTHER = 23'h010042;
  logic ref_clk_in = 1'b0;
  logic rstn_in, byte_mode_in, req_valid_in;
  req_t req_in;
  logic req_ready_out, resp_valid_out, flash_dq_oe_out;
  resp_t resp_out, rsp;
  mode_t mode_out;
  logic [ADDR_W-1:0] flash_addr_out;
  logic [DATA_W-1:0] flash_dq_out, flash_dq_in;
  logic flash_ce_n_out, flash_we_n_out, flash_oe_n_out, flash_byte_n_out;
  int failures = 0;
  int total_checks = 0;
  int w;

  flash_host_ctrl #(.COLLECT_CYC(400)) u_flash_host_ctrl (.ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in), .byte_mode_in(byte_mode_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .req_ready_out(req_ready_out), .resp_valid_out(resp_valid_out),
    .resp_out(resp_out), .mode_out(mode_out), .flash_addr_out(flash_addr_out),
    .flash_dq_out(flash_dq_out), .flash_dq_oe_out(flash_dq_oe_out),
    .flash_dq_in(flash_dq_in), .flash_ce_n_out(flash_ce_n_out),
    .flash_we_n_out(flash_we_n_out), .flash_oe_n_out(flash_oe_n_out),
    .flash_byte_n_out(flash_byte_n_out));

  flash_device_model u_flash_device_model (.rstn_in(rstn_in), .addr_in(flash_addr_out),
    .dq_in(flash_dq_out), .ce_n_in(flash_ce_n_out), .we_n_in(flash_we_n_out),
    .oe_n_in(flash_oe_n_out), .dq_out(flash_dq_in));

  always #5 ref_clk_in = ~ref_clk_in;

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one request, held until taken, then wait for its answer
  task automatic issue(input cmd_t c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    w = u_flash_device_model.n_wr;
    @(posedge ref_clk_in);
    #1;
    req_valid_in = 1'b1;
    req_in = '{cmd: c, addr: a, data: d};
    while (req_ready_out !== 1'b1 && n < 100) begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end
    @(posedge ref_clk_in);
    #1;
    req_valid_in = 1'b0;
    while (resp_valid_out !== 1'b1 && n < 5000) begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end
    chk("answer", 32'h1, {31'h0, resp_valid_out});
    rsp = resp_out;
  endtask : issue

  task automatic chk_wr(input int k, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    chk("write addr", 32'(a), 32'(u_flash_device_model.wr_log[k % 64][DATA_W +: ADDR_W]));
    chk("write data", {24'h0, d}, {16'h0, u_flash_device_model.wr_log[k % 64][DATA_W-1:0]});
  endtask : chk_wr

  task automatic chk_mode(input mode_t m);
    chk("mode", 32'(m), 32'(mode_out));
  endtask : chk_mode

  task automatic t_refuse();
    cmd_t bad [4];
    bad = '{CMD_SUSPEND, CMD_RESUME, CMD_BYP_PROG, CMD_BYP_RESET};
    chk_mode(MODE_READ);
    for (int i = 0; i < 4; i++) begin
      issue(bad[i], SEC_A, 16'h0000);
      chk("refused", 32'h1, {31'h0, rsp.refused});
      chk("no write", w, u_flash_device_model.n_wr);
    end
    $display("test refuse done");
  endtask : t_refuse

  task automatic t_erase();
    issue(CMD_SECTOR_ERASE, SEC_A, 16'h0000);
    chk_mode(MODE_COLLECT);
    chk_wr(w, 23'h000555, 8'haa);
    chk_wr(w + 1, 23'h0002aa, 8'h55);
    chk_wr(w + 2, 23'h000555, 8'h80);
    chk_wr(w + 3, 23'h000555, 8'haa);
    chk_wr(w + 4, 23'h0002aa, 8'h55);
    chk_wr(w + 5, SEC_A, 8'h30);
    // a second sector inside the collection window is one write only
    issue(CMD_SECTOR_ERASE, SEC_B, 16'h0000);
    chk_mode(MODE_COLLECT);
    chk_wr(w, SEC_B, 8'h30);
    chk("one write", w + 1, u_flash_device_model.n_wr);
    $display("test erase done");
  endtask : t_erase

  task automatic t_suspend();
    logic et;
    issue(CMD_SUSPEND, SEC_A, 16'h0000);
    chk_mode(MODE_SUSP);
    chk_wr(w, SEC_A, 8'hb0);
    chk("one write", w + 1, u_flash_device_model.n_wr);
    issue(CMD_READ, SEC_A, 16'h0000);
    et = rsp.erase_toggle_bit;
    chk("poll bit", 32'h1, {31'h0, rsp.polling_status_bit});
    issue(CMD_READ, SEC_B, 16'h0000);
    chk("etoggle", {31'h0, ~et}, {31'h0, rsp.erase_toggle_bit});
    issue(CMD_READ, OTHER, 16'h0000);
    chk("array", 32'(OTHER[15:0] ^ 16'h5a5a), 32'(rsp.data));
    issue(CMD_RESET, OTHER, 16'h0000);
    chk_wr(w, 23'h000000, 8'hf0);
    chk_mode(MODE_SUSP);
    $display("test suspend done");
  endtask : t_suspend

  task automatic t_resume();
    int n;
    n = 0;
    issue(CMD_RESUME, SEC_B, 16'h0000);
    chk_mode(MODE_ERASE);
    chk_wr(w, SEC_B, 8'h30);
    issue(CMD_RESUME, SEC_B, 16'h0000);
    chk("refused", 32'h1, {31'h0, rsp.refused});
    issue(CMD_READ, SEC_B, 16'h0000);
    chk("poll bit", 32'h0, {31'h0, rsp.polling_status_bit});
    issue(CMD_SUSPEND, SEC_B, 16'h0000);
    chk("taken", 32'h0, {31'h0, rsp.refused});
    chk_mode(MODE_SUSP_WAIT);
    while (mode_out !== MODE_SUSP && n < 2100) begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end
    chk("suspend wait", 32'(SUSPEND_CYC + 1), n);
    $display("test resume done");
  endtask : t_resume

  task automatic t_bypass();
    logic [ADDR_W+DATA_W-1:0] e;
    @(posedge ref_clk_in);
    #1;
    rstn_in = 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1;
    rstn_in = 1'b1;
    chk_mode(MODE_READ);
    byte_mode_in = 1'b1;
    issue(CMD_BYP_ENTER, OTHER, 16'h0000);
    chk_mode(MODE_BYPASS);
    chk_wr(w, 23'h000aaa, 8'haa);
    chk_wr(w + 1, 23'h000555, 8'h55);
    chk_wr(w + 2, 23'h000aaa, 8'h20);
    chk("byte pin", 32'h0, {31'h0, flash_byte_n_out});
    byte_mode_in = 1'b0;
    issue(CMD_BYP_PROG, OTHER, 16'h1234);
    chk_wr(w, 23'h000000, 8'ha0);
    e = u_flash_device_model.wr_log[(w + 1) % 64];
    chk("payload addr", 32'(OTHER), 32'(e[DATA_W +: ADDR_W]));
    chk("payload data", 32'h1234, 32'(e[DATA_W-1:0]));
    issue(CMD_SECTOR_ERASE, SEC_A, 16'h0000);
    chk("refused", 32'h1, {31'h0, rsp.refused});
    issue(CMD_BYP_RESET, SEC_A, 16'h0000);
    chk_wr(w, SEC_A, 8'h90);
    chk_wr(w + 1, 23'h000000, 8'h00);
    chk_mode(MODE_READ);
    $display("test bypass done");
  endtask : t_bypass

  initial begin
    rstn_in = 1'b0;
    byte_mode_in = 1'b0;
    req_valid_in = 1'b0;
    req_in = '0;
    repeat (4) @(posedge ref_clk_in);
    #1;
    rstn_in = 1'b1;
    chk("ready", 32'h1, {31'h0, req_ready_out});
    chk("ce idle", 32'h1, {31'h0, flash_ce_n_out});
    t_refuse();
    t_erase();
    t_suspend();
    t_resume();
    t_bypass();
    conclude();
  end

  // the whole run needs well under 10000 cycles
  initial begin
    #400000;
    failures++;
    conclude();
  end
endmodule : test_flash_host_ctrl
